/* File: hdl/rxqhr_pkg.sv */
// Shared constants and types of the receive queue host read-out block.
// Assumes one clock, clk_sys, and a classic Wishbone master with 32-bit data.
package rxqhr_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int ADR_W = 11;
    localparam logic [8:0] IX_HDR_STATUS = 9'h17C;
    localparam logic [8:0] IX_HDR_CNT = 9'h17E;
    localparam logic [8:0] IX_QCTRL = 9'h182;
    localparam logic [8:0] IX_DPTR = 9'h186;
    localparam logic [8:0] IX_IRQ_MASK = 9'h190;
    localparam logic [8:0] IX_IRQ_STATUS = 9'h192;
    localparam logic [8:0] IX_FRM_COUNT = 9'h1B8;
    localparam logic [8:0] IX_DATA = 9'h1C0;

    // ----------------------------------------------------------------
    // Field positions, masks, the dummy item and the pointer step
    // ----------------------------------------------------------------
    localparam int QC_BURST = 3;
    localparam int DP_AUTOINC = 14;
    localparam int IRQ_RX = 13;
    localparam int FC_LSB = 8;
    localparam int FC_W = 8;
    localparam int PTR_W = 11;
    localparam int CNT_W = 12;
    localparam logic [15:0] QCTRL_MASK = 16'h0008;
    localparam logic [15:0] DPTR_MASK = 16'h47FF;
    localparam logic [15:0] DUMMY_DATA = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_STEP = 11'h002;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RXQHR_IDLE = 2'b00,
        RXQHR_DUMMY = 2'b01,
        RXQHR_DATA = 2'b10
    } rxqhr_burst_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rxqhr_wb_req_t;

    typedef struct packed {
        logic [15:0] status;
        logic [CNT_W-1:0] cnt;
    } rxqhr_hdr_t;

    // Applies the two low byte lanes of a write to a 16-bit register
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [3:0] sel);
        laneMerge = old;
        if (sel[0]) begin
            laneMerge[7:0] = nw[7:0];
        end
        if (sel[1]) begin
            laneMerge[15:8] = nw[15:8];
        end
    endfunction

endpackage

/* File: hdl/rxqhr_frame_store.sv */
// Slot-based store of received frames: one slot per frame, headers kept per slot.
// Assumes the MAC side delivers 16-bit words with a header on the last word.
module rxqhr_frame_store import rxqhr_pkg::*; #(
    parameter int SLOTS = 4,
    parameter int SLOT_WORDS = 1024,
    parameter int SLOT_W = $clog2(SLOTS),
    parameter int WORD_W = $clog2(SLOT_WORDS)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Incoming frames
    input wire logic inValid,
    output logic inReady,
    input wire logic [15:0] inWord,
    input wire logic inLast,
    input wire rxqhr_hdr_t inHdr,
    // Queue view
    output logic frameDone,
    output logic [SLOT_W:0] queued,
    input wire logic [SLOT_W-1:0] hdrIdx,
    output rxqhr_hdr_t hdrOut,
    input wire logic [SLOT_W-1:0] dataIdx,
    output rxqhr_hdr_t dataHdr,
    input wire logic [SLOT_W+WORD_W-1:0] rdAddr,
    output logic [15:0] rdWord,
    input wire logic freeSlot
);
    typedef struct packed {
        logic [SLOT_W-1:0] wrSlot;
        logic [WORD_W-1:0] wrPtr;
        logic [SLOT_W:0] queued;
        logic done;
    } rxqhr_store_t;

    rxqhr_store_t s;
    rxqhr_store_t next_s;
    logic [15:0] mem [SLOTS*SLOT_WORDS];
    rxqhr_hdr_t hdrs [SLOTS];
    logic take;

    // Accept words while a free slot exists
    assign inReady = (s.queued < (SLOT_W+1)'(SLOTS));
    assign take = inValid && inReady;
    assign frameDone = s.done;
    assign queued = s.queued;
    assign hdrOut = hdrs[hdrIdx];
    assign dataHdr = hdrs[dataIdx];

    // Write pointer, slot ring and occupancy
    always_comb begin
        next_s = s;
        next_s.done = take && inLast;
        if (take) begin
            if (inLast) begin
                next_s.wrSlot = s.wrSlot + 1'b1;
                next_s.wrPtr = '0;
            end else if (s.wrPtr != '1) begin
                next_s.wrPtr = s.wrPtr + 1'b1;
            end
        end
        next_s.queued = s.queued + (SLOT_W+1)'(next_s.done) - (SLOT_W+1)'(freeSlot);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Frame words, headers and registered read port
    always_ff @(posedge clk_sys) begin
        if (take) begin
            mem[{s.wrSlot, s.wrPtr}] <= inWord;
        end
        if (take && inLast) begin
            hdrs[s.wrSlot] <= inHdr;
        end
        rdWord <= mem[rdAddr];
    end
endmodule

/* File: hdl/rxqhr_irq.sv */
// Sticky interrupt status with mask and one level output.
// Assumes events are one-cycle pulses from the same clock.
module rxqhr_irq import rxqhr_pkg::*; (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Events and software access
    input wire logic [15:0] rxEvent,
    input wire logic w1cWrite,
    input wire logic [15:0] w1cData,
    input wire logic readClear,
    input wire logic maskWrite,
    input wire logic [15:0] maskData,
    // State
    output logic [15:0] status,
    output logic [15:0] mask,
    output logic irq
);
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] mask;
        logic irq;
    } rxqhr_irq_t;

    rxqhr_irq_t s;
    rxqhr_irq_t next_s;

    // Clears by write-one or by read, a new event wins over both
    always_comb begin
        next_s = s;
        if (w1cWrite) begin
            next_s.status = s.status & ~w1cData;
        end
        if (readClear) begin
            next_s.status = '0;
        end
        next_s.status = next_s.status | rxEvent;
        if (maskWrite) begin
            next_s.mask = maskData;
        end
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign status = s.status;
    assign mask = s.mask;
    assign irq = s.irq;

    a_clear_all: assert property (@(posedge clk_sys) disable iff (reset)
        (w1cWrite && w1cData == 16'hFFFF && rxEvent == '0) |=> status == '0)
        else $error("write of all ones left a status bit set");
endmodule

/* File: hdl/rxqhr_host_readout.sv */
// Receive queue host read-out: frame store, interrupt and Wishbone registers.
// Assumes a classic Wishbone master that leaves a gap cycle between requests.
// Summary of operation
// - Frames can be taken by polling the status or after the interrupt, same data either way.
// - Each queue read burst returns one dummy item first, which the host throws away.
// - Writing one to the receive interrupt bit latches the queued frame count.
// - Reading the frame count presents the first queued frame's status and byte count.
// - Reading both header registers advances them to the next queued frame.
// - Setting the burst bit of the queue control register starts a data port burst.
// - With the auto-increment bit set, each data read after the dummy item steps the queue address.
// - Writing all ones to the interrupt status clears every pending bit.
// - The frame count field in bits 15 to 8 holds the frames queued when one was written to the receive interrupt bit.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
module rxqhr_host_readout import rxqhr_pkg::*; #(
    parameter int SLOTS = 4,
    parameter int SLOT_WORDS = 1024
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone slave
    input wire rxqhr_wb_req_t wbReq,
    output logic wbAck,
    output logic [31:0] wbDat,
    // Received frame stream
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [15:0] rxWord,
    input wire logic rxLast,
    input wire rxqhr_hdr_t rxHdr,
    // Interrupt
    output logic irq
);
    localparam int SLOT_W = $clog2(SLOTS);
    localparam int WORD_W = $clog2(SLOT_WORDS);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        rxqhr_burst_t burst;
        logic [15:0] qctrl;
        logic [15:0] dptr;
        logic [FC_W-1:0] frameCnt;
        logic [SLOT_W-1:0] hdrSlot;
        logic [SLOT_W-1:0] dataSlot;
        logic dataOwned;
        logic hdrShown;
        logic gotSt;
        logic gotCnt;
    } rxqhr_state_t;

    rxqhr_state_t s;
    rxqhr_state_t next_s;

    logic access;
    logic [8:0] idx;
    logic [15:0] wdat;
    logic [15:0] qNew;
    logic [PTR_W-1:0] ptr;
    logic frameDone;
    logic [SLOT_W:0] queued;
    logic [SLOT_W:0] pending;
    logic hdrValid;
    rxqhr_hdr_t hdrOut;
    rxqhr_hdr_t dataHdr;
    logic [15:0] rdWord;
    logic doFree;
    logic w1cWrite;
    logic readClear;
    logic maskWrite;
    logic [15:0] rxEvent;
    logic [15:0] irqStatus;
    logic [15:0] irqMask;

    // ----------------------------------------------------------------
    // Decode and derived state
    // ----------------------------------------------------------------
    assign access = wbReq.cyc && wbReq.stb && !s.ack;
    assign idx = wbReq.adr[ADR_W-1:2];
    assign wdat = wbReq.dat[15:0];
    assign qNew = laneMerge(s.qctrl, wdat, wbReq.sel) & QCTRL_MASK;
    assign ptr = s.dptr[PTR_W-1:0];
    assign pending = queued - (SLOT_W+1)'(s.dataOwned);
    assign hdrValid = s.hdrShown && (pending != '0);

    // Frame completion raises the receive interrupt bit
    always_comb begin
        rxEvent = '0;
        rxEvent[IRQ_RX] = frameDone;
    end

    // ----------------------------------------------------------------
    // Register access and queue stepping
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.ack = access;
        doFree = 1'b0;
        w1cWrite = 1'b0;
        readClear = 1'b0;
        maskWrite = 1'b0;
        if (access) begin
            next_s.rdat = '0;
            if (wbReq.we) begin
                case (idx)
                    IX_QCTRL: begin
                        next_s.qctrl = qNew;
                        if (!qNew[QC_BURST]) begin
                            next_s.burst = RXQHR_IDLE;
                        end else if (!s.qctrl[QC_BURST]) begin
                            next_s.burst = RXQHR_DUMMY;
                        end
                    end
                    IX_DPTR: begin
                        next_s.dptr = laneMerge(s.dptr, wdat, wbReq.sel) & DPTR_MASK;
                    end
                    IX_IRQ_MASK: begin
                        maskWrite = 1'b1;
                    end
                    IX_IRQ_STATUS: begin
                        w1cWrite = 1'b1;
                        if (wbReq.sel[1] && wdat[IRQ_RX]) begin
                            next_s.frameCnt = FC_W'(pending);
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (idx)
                    IX_HDR_STATUS: begin
                        next_s.rdat[15:0] = hdrValid ? hdrOut.status : '0;
                        next_s.gotSt = hdrValid;
                    end
                    IX_HDR_CNT: begin
                        next_s.rdat[CNT_W-1:0] = hdrValid ? hdrOut.cnt : '0;
                        next_s.gotCnt = hdrValid;
                    end
                    IX_QCTRL: next_s.rdat[15:0] = s.qctrl;
                    IX_DPTR: next_s.rdat[15:0] = s.dptr;
                    IX_IRQ_MASK: next_s.rdat[15:0] = irqMask;
                    IX_IRQ_STATUS: begin
                        next_s.rdat[15:0] = irqStatus;
                        readClear = 1'b1;
                    end
                    IX_FRM_COUNT: begin
                        next_s.rdat[FC_LSB+FC_W-1:FC_LSB] = s.frameCnt;
                        next_s.hdrShown = 1'b1;
                    end
                    IX_DATA: begin
                        case (s.burst)
                            RXQHR_DUMMY: begin
                                next_s.rdat[15:0] = DUMMY_DATA;
                                next_s.burst = RXQHR_DATA;
                            end
                            RXQHR_DATA: begin
                                if (s.dataOwned && {1'b0, ptr} < dataHdr.cnt) begin
                                    next_s.rdat[15:0] = rdWord;
                                end
                                if (s.dptr[DP_AUTOINC]) begin
                                    next_s.dptr[PTR_W-1:0] = ptr + PTR_STEP;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
        end
        // Both headers read: current frame becomes the data frame
        if (next_s.gotSt && next_s.gotCnt) begin
            doFree = s.dataOwned;
            next_s.dataSlot = s.hdrSlot;
            next_s.dataOwned = 1'b1;
            next_s.hdrSlot = s.hdrSlot + 1'b1;
            next_s.gotSt = 1'b0;
            next_s.gotCnt = 1'b0;
            next_s.dptr[PTR_W-1:0] = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wbAck = s.ack;
    assign wbDat = s.rdat;

    // ----------------------------------------------------------------
    // Frame store and interrupt
    // ----------------------------------------------------------------
    rxqhr_frame_store #(
        .SLOTS(SLOTS),
        .SLOT_WORDS(SLOT_WORDS)
    ) u_store (
        .clk_sys(clk_sys),
        .reset(reset),
        .inValid(rxValid),
        .inReady(rxReady),
        .inWord(rxWord),
        .inLast(rxLast),
        .inHdr(rxHdr),
        .frameDone(frameDone),
        .queued(queued),
        .hdrIdx(s.hdrSlot),
        .hdrOut(hdrOut),
        .dataIdx(s.dataSlot),
        .dataHdr(dataHdr),
        .rdAddr({s.dataSlot, ptr[WORD_W:1]}),
        .rdWord(rdWord),
        .freeSlot(doFree)
    );

    rxqhr_irq u_irq (
        .clk_sys(clk_sys),
        .reset(reset),
        .rxEvent(rxEvent),
        .w1cWrite(w1cWrite),
        .w1cData(laneMerge(16'h0000, wdat, wbReq.sel)),
        .readClear(readClear),
        .maskWrite(maskWrite),
        .maskData(laneMerge(irqMask, wdat, wbReq.sel)),
        .status(irqStatus),
        .mask(irqMask),
        .irq(irq)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_event_sticky: assert property (@(posedge clk_sys) disable iff (reset)
        frameDone |=> irqStatus[IRQ_RX])
        else $error("completed frame did not set the receive status bit");

    a_dummy_first: assert property (@(posedge clk_sys) disable iff (reset)
        (access && !wbReq.we && idx == IX_DATA && s.burst == RXQHR_DUMMY)
        |=> (wbAck && wbDat == 32'h0 && s.burst == RXQHR_DATA))
        else $error("first burst read was not the dummy item");

    a_count_latch: assert property (@(posedge clk_sys) disable iff (reset)
        (access && wbReq.we && idx == IX_IRQ_STATUS && wbReq.sel[1] && wdat[IRQ_RX])
        |=> s.frameCnt == FC_W'($past(pending)))
        else $error("frame count not latched on interrupt clear");

    a_hdr_present: assert property (@(posedge clk_sys) disable iff (reset)
        (access && !wbReq.we && idx == IX_FRM_COUNT) |=> s.hdrShown ##1 !s.ack)
        else $error("frame count read did not present the header");

    a_hdr_advance: assert property (@(posedge clk_sys) disable iff (reset)
        (access && !wbReq.we && idx == IX_HDR_CNT && s.gotSt && hdrValid)
        |=> (s.dataOwned && s.hdrSlot == SLOT_W'($past(s.hdrSlot) + 1'b1)))
        else $error("headers did not advance after both were read");

    a_burst_start: assert property (@(posedge clk_sys) disable iff (reset)
        (access && wbReq.we && idx == IX_QCTRL && qNew[QC_BURST] && !s.qctrl[QC_BURST])
        |=> s.burst == RXQHR_DUMMY)
        else $error("burst bit did not start a burst");

    a_auto_inc: assert property (@(posedge clk_sys) disable iff (reset)
        (access && !wbReq.we && idx == IX_DATA && s.burst == RXQHR_DATA
         && s.dptr[DP_AUTOINC])
        |=> ptr == PTR_W'($past(ptr) + PTR_STEP))
        else $error("queue address did not step on data access");

    a_pad_reads: assert property (@(posedge clk_sys) disable iff (reset)
        (access && !wbReq.we && idx == IX_DATA && s.burst == RXQHR_DATA
         && {1'b0, ptr} >= dataHdr.cnt)
        |=> (wbDat == 32'h0 && $stable(s.dataSlot)))
        else $error("padding read returned data or moved frames");

    a_ack_pulse: assert property (@(posedge clk_sys) disable iff (reset)
        wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");
endmodule

/* File: dv/rxqhr_host_model.sv */
// Host processor model: a classic Wishbone master making single accesses.
// Assumes the slave answers with one ack pulse and holds read data after it.
module rxqhr_host_model import rxqhr_pkg::*; (
    // Clock
    input wire logic clk_sys,
    // Wishbone master side
    output rxqhr_wb_req_t wbReq,
    input wire logic wbAck,
    input wire logic [31:0] wbDat
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Idle bus at time zero
    // ----------------------------------------------------------------
    initial begin
        wbReq = '0;
    end

    // ----------------------------------------------------------------
    // Single access, one at a time with a gap cycle after it
    // ----------------------------------------------------------------
    // Request held until ack is seen at a rising edge, data taken at that edge
    task automatic access(input logic we, input logic [8:0] idx, input logic [15:0] wdat,
                          output logic [31:0] rdat);
        @(posedge clk_sys);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h3,
                   dat: {16'h0000, wdat}};
        do @(posedge clk_sys); while (wbAck !== 1'b1);
        rdat = wbDat;
        // Released lines show inverted values, never the stale request
        wbReq <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~{idx, 2'b00}, sel: 4'hC,
                   dat: ~{16'h0000, wdat}};
    endtask
endmodule

/* File: dv/test_rxqhr_host_readout.sv */
// Self-checking bench of the receive queue host read-out block.
// Assumes the host model for bus access; the bench itself feeds frames.
module test_rxqhr_host_readout import rxqhr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0] status;
        logic [11:0] cnt;
        logic autoInc;
    } rxqhr_row_t;

    logic clk_sys;
    logic reset;
    rxqhr_wb_req_t wbReq;
    logic wbAck;
    logic [31:0] wbDat;
    logic rxValid;
    logic rxReady;
    logic [15:0] rxWord;
    logic rxLast;
    rxqhr_hdr_t rxHdr;
    logic irq;
    int errTotal = 0;
    int comparisons = 0;
    // Frames: header status, byte count, auto-increment for read-out
    rxqhr_row_t rows [3] = '{'{16'h8101, 12'h041, 1'b1}, '{16'h4202, 12'h004, 1'b1},
                             '{16'h2303, 12'h007, 1'b0}};

    // ----------------------------------------------------------------
    // Clock and instances
    // ----------------------------------------------------------------
    always #2 clk_sys = ~clk_sys;

    rxqhr_host_readout #(.SLOTS(4), .SLOT_WORDS(64)) u_rxqhr_host_readout (
        .clk_sys(clk_sys), .reset(reset), .wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat),
        .rxValid(rxValid), .rxReady(rxReady), .rxWord(rxWord), .rxLast(rxLast),
        .rxHdr(rxHdr), .irq(irq));

    rxqhr_host_model u_rxqhr_host_model (
        .clk_sys(clk_sys), .wbReq(wbReq), .wbAck(wbAck), .wbDat(wbDat));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Register write
    task automatic wr(input logic [8:0] idx, input logic [15:0] d);
        logic [31:0] unused;
        u_rxqhr_host_model.access(1'b1, idx, d, unused);
    endtask

    // Register read and compare
    task automatic rdChk(input string what, input logic [8:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        u_rxqhr_host_model.access(1'b0, idx, 16'h0000, d);
        chk(what, exp, d);
    endtask

    // Feed one frame, holding each word until it is taken
    task automatic sendFrame(input int f);
        int n;
        n = (rows[f].cnt + 1) / 2;
        for (int k = 0; k < n; k++) begin
            @(posedge clk_sys);
            rxValid <= 1'b1;
            rxWord <= {4'hA, 4'(f), 8'(k)};
            rxLast <= (k == n - 1);
            rxHdr <= '{status: rows[f].status, cnt: rows[f].cnt};
            do @(negedge clk_sys); while (rxReady !== 1'b1);
        end
        @(posedge clk_sys);
        rxValid <= 1'b0;
        rxLast <= 1'b0;
        rxWord <= ~rxWord;
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        errTotal++;
        $display("unexpected watchdog: expected done, seen timeout");
        test_done();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int w;
        clk_sys = 1'b0;
        reset = 1'b1;
        rxValid = 1'b0;
        rxWord = 16'h0000;
        rxLast = 1'b0;
        rxHdr = '0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk("ack after reset", 32'h0, {31'h0, wbAck});
        chk("irq after reset", 32'h0, {31'h0, irq});
        chk("ready after reset", 32'h1, {31'h0, rxReady});
        rdChk("mask reset", IX_IRQ_MASK, 32'h0);
        rdChk("status reset", IX_IRQ_STATUS, 32'h0);
        rdChk("count reset", IX_FRM_COUNT, 32'h0);
        rdChk("header reset", IX_HDR_STATUS, 32'h0);
        rdChk("unmapped read", 9'h001, 32'h0);
        $display("test reset done");
        // Polling: status set while masked, read clears it
        sendFrame(0);
        repeat (3) @(negedge clk_sys);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdChk("status poll", IX_IRQ_STATUS, 32'h2000);
        rdChk("status after read", IX_IRQ_STATUS, 32'h0);
        // Interrupt path: unmask, raise, clear with all ones
        wr(IX_IRQ_MASK, 16'h2000);
        sendFrame(1);
        sendFrame(2);
        repeat (3) @(negedge clk_sys);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(IX_IRQ_STATUS, 16'hFFFF);
        repeat (2) @(negedge clk_sys);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rdChk("status cleared", IX_IRQ_STATUS, 32'h0);
        rdChk("frame count", IX_FRM_COUNT, 32'h0300);
        $display("test interrupt done");
        // Read-out of every frame: headers, burst, dummy, padded data
        for (int f = 0; f < 3; f++) begin
            rdChk("header status", IX_HDR_STATUS, {16'h0, rows[f].status});
            rdChk("header count", IX_HDR_CNT, {20'h0, rows[f].cnt});
            wr(IX_DPTR, {1'b0, rows[f].autoInc, 14'h0000});
            wr(IX_QCTRL, 16'h0008);
            rdChk("dummy item", IX_DATA, 32'h0);
            for (int j = 0; j < (rows[f].cnt + 3) / 4 * 2; j++) begin
                w = rows[f].autoInc ? j : 0;
                rdChk("frame data", IX_DATA,
                      (2 * w < rows[f].cnt) ? {16'h0, 4'hA, 4'(f), 8'(w)} : 32'h0);
            end
            wr(IX_QCTRL, 16'h0000);
            $display("test frame %0d done", f);
        end
        // Awkward cases: empty header view, data port outside a burst
        rdChk("header after last", IX_HDR_STATUS, 32'h0);
        rdChk("data outside burst", IX_DATA, 32'h0);
        // Queue full: the owned frame plus three new ones stall the stream
        for (int f = 0; f < 3; f++) begin
            sendFrame(f);
        end
        @(negedge clk_sys);
        chk("ready when full", 32'h0, {31'h0, rxReady});
        $display("test edge cases done");
        test_done();
    end
endmodule
